// *** rxeq_pkg.sv ***
// Shared constants and types for the receiver equalizer and interrupt mask register bank
package rxeq_pkg;

  // Channel register offsets
  localparam logic [7:0] OFF_EQ_STAGE_BOOST = 8'h03;
  localparam logic [7:0] OFF_LOW_RATE_EQ_BYPASS = 8'h0d;
  localparam logic [7:0] OFF_EQ_BYPASS_POWER_DOWN = 8'h13;
  localparam logic [7:0] OFF_BOOST_OVERRIDE = 8'h2d;
  localparam logic [7:0] OFF_DRIVEN_BOOST = 8'h52;
  localparam logic [7:0] OFF_INTERRUPT_STATUS = 8'h54;
  localparam logic [7:0] OFF_INTERRUPT_MASK = 8'h56;

  // Reset values
  localparam logic [7:0] RST_EQ_STAGE_BOOST = 8'h80;
  localparam logic [7:0] RST_LOW_RATE_EQ_BYPASS = 8'h00;
  localparam logic [7:0] RST_EQ_BYPASS_POWER_DOWN = 8'h90;
  localparam logic [7:0] RST_BOOST_OVERRIDE = 8'h88;
  localparam logic [7:0] RST_INTERRUPT_MASK = 8'h00;
  localparam logic [7:0] RST_INTERRUPT_STATUS = 8'h00;

  // Writable bits of each register; reserved bits of the bypass register keep their value
  localparam logic [7:0] WMASK_LOW_RATE_EQ_BYPASS = 8'h01;
  localparam logic [7:0] WMASK_EQ_BYPASS_POWER_DOWN = 8'h6a;
  localparam logic [7:0] WMASK_BOOST_OVERRIDE = 8'h08;
  localparam logic [7:0] WMASK_INTERRUPT_MASK = 8'h7f;

  // Interrupt mask and status bit positions
  localparam int BIT_LOCK_GAINED = 6;
  localparam int BIT_INPUT_B_PRESENT = 5;
  localparam int BIT_INPUT_A_PRESENT = 4;
  localparam int BIT_EYE_THRESHOLD = 3;
  localparam int BIT_LOCK_LOST = 2;
  localparam int BIT_INPUT_B_ABSENT = 1;
  localparam int BIT_INPUT_A_ABSENT = 0;
  localparam int BIT_SELECTED_DETECT = 7;

  // Stage boost field positions (low bit of each 2-bit field)
  localparam int POS_STAGE_ZERO = 6;
  localparam int POS_STAGE_ONE = 4;
  localparam int POS_STAGE_TWO = 2;
  localparam int POS_STAGE_THREE = 0;

  // Other control bit positions
  localparam int BIT_LOW_RATE_AUTO_BYPASS = 0;
  localparam int BIT_INPUT_A_DETECTOR_OFF = 6;
  localparam int BIT_INPUT_B_DETECTOR_OFF = 5;
  localparam int BIT_SELECTED_EQUALIZER_OFF = 3;
  localparam int BIT_LATE_STAGE_BYPASS = 1;
  localparam int BIT_BOOST_OVERRIDE_ENABLE = 3;

  // Number of raw analog levels watched for events
  localparam int NUM_LEVELS = 4;
  localparam int LVL_LOCK = 3;
  localparam int LVL_INPUT_B = 2;
  localparam int LVL_INPUT_A = 1;
  localparam int LVL_EYE = 0;

  // Controls driven toward the analog receiver
  typedef struct packed {
    logic [7:0] stageBoost;
    logic eqBypass;
    logic lateStageBypass;
    logic inputAEqOn;
    logic inputBEqOn;
    logic inputADetectorOff;
    logic inputBDetectorOff;
  } rxeq_ctrl_type;

  localparam rxeq_ctrl_type RST_CTRL = '{
    stageBoost: RST_EQ_STAGE_BOOST,
    eqBypass: 1'b0,
    lateStageBypass: 1'b0,
    inputAEqOn: 1'b0,
    inputBEqOn: 1'b0,
    inputADetectorOff: 1'b0,
    inputBDetectorOff: 1'b0
  };

endpackage

// *** rxeq_event_capture.sv ***
// Synchronises receiver status levels and records their edges as clear-on-read status
`timescale 1ns/1ps
module rxeq_event_capture
  import rxeq_pkg::*;
#(
  parameter int SYNC_STAGES = 2
)
(
  input wire logic ref_clk, // 20 MHz clock
  input wire logic rst_n, // Asynchronous reset, active low
  input wire logic [NUM_LEVELS-1:0] rawLevels, // Analog status levels
  input wire logic clearStatus, // One-cycle pulse: status was read
  input wire logic [7:0] irqMask, // Interrupt mask register
  output logic [NUM_LEVELS-1:0] levels_r, // Synchronised levels
  output logic [6:0] status_r, // Sticky event status
  output logic irq_r // Masked interrupt request
);

  initial
  begin
    if (SYNC_STAGES < 2)
    begin
      $error("SYNC_STAGES must be at least 2");
    end
  end

  logic [NUM_LEVELS-1:0] syncChain_r [SYNC_STAGES];
  logic [NUM_LEVELS-1:0] prevLevels_r;
  logic [6:0] events;
  logic [6:0] status_nxt;
  logic irq_nxt;

  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      for (int i = 0; i < SYNC_STAGES; i++)
      begin
        syncChain_r[i] <= '0;
      end
    end
    else
    begin
      syncChain_r[0] <= rawLevels;
      for (int i = 1; i < SYNC_STAGES; i++)
      begin
        syncChain_r[i] <= syncChain_r[i-1];
      end
    end
  end

  wire logic [NUM_LEVELS-1:0] syncLevels = syncChain_r[SYNC_STAGES-1];
  wire logic [NUM_LEVELS-1:0] rising = syncLevels & ~prevLevels_r;
  wire logic [NUM_LEVELS-1:0] falling = ~syncLevels & prevLevels_r;

  assign events[BIT_LOCK_GAINED] = rising[LVL_LOCK];
  assign events[BIT_INPUT_B_PRESENT] = rising[LVL_INPUT_B];
  assign events[BIT_INPUT_A_PRESENT] = rising[LVL_INPUT_A];
  assign events[BIT_EYE_THRESHOLD] = rising[LVL_EYE];
  assign events[BIT_LOCK_LOST] = falling[LVL_LOCK];
  assign events[BIT_INPUT_B_ABSENT] = falling[LVL_INPUT_B];
  assign events[BIT_INPUT_A_ABSENT] = falling[LVL_INPUT_A];

  // A new event in the reading cycle survives the clear
  assign status_nxt = (clearStatus ? 7'h00 : status_r) | events;
  assign irq_nxt = |(status_nxt & irqMask[6:0]);

  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      prevLevels_r <= '0;
      levels_r <= '0;
      status_r <= RST_INTERRUPT_STATUS[6:0];
      irq_r <= 1'b0;
    end
    else
    begin
      prevLevels_r <= syncLevels;
      levels_r <= syncLevels;
      status_r <= status_nxt;
      irq_r <= irq_nxt;
    end
  end

endmodule

// *** rxeq_regs.sv ***
// Receiver equalizer controls and interrupt mask register bank of one channel
// Notes on behaviour
// - Mask bit 6 enables an interrupt when clock recovery gains lock.
// - Mask bit 5 enables an interrupt when input B detector asserts.
// - Mask bit 4 enables an interrupt when input A detector asserts.
// - Mask bit 3 enables an interrupt when the eye threshold is reached.
// - Mask bit 2 enables an interrupt when clock recovery loses lock.
// - Mask bits 1 and 0 enable loss-of-signal interrupts for inputs B and A.
// - Boost register holds four 2-bit stage fields, stage zero on top; resets 0x80.
// - Adaptation writes the stage fields itself while override is clear, so reads then show adapted values.
// - Host boost values drive the equalizer only while override is set.
// - Boost actually driven is readable at its own address.
// - Low-rate bypass bit bypasses the equalizer at 270 Mbps.
// - Manual bypass bypasses at every rate and makes auto-bypass irrelevant.
// - Bits 6 and 5 power down the signal detectors of inputs A and B.
// - Bit 3 powers down the selected equalizer; unselected one stays off.
// - Bit 1 bypasses the third and fourth equalizer stages.
// - Bypass register resets to 0x90; interrupt mask resets to zero.
// - Interrupt status records causes and clears when read.
// - Override register bit 3 enables the host boost override.
`timescale 1ns/1ps
module rxeq_regs
  import rxeq_pkg::*;
#(
  parameter int DATA_W = 8,
  parameter int SYNC_STAGES = 2
)
(
  input wire logic ref_clk, // 20 MHz clock
  input wire logic rst_n, // Asynchronous reset, active low
  input wire logic channelSpaceSelect, // Channel space selected by host
  input wire logic [7:0] regAddr, // Register address
  input wire logic [DATA_W-1:0] regWrData, // Write data
  input wire logic regWrEn, // Write strobe, one cycle
  input wire logic regRdEn, // Read strobe, one cycle
  output logic [DATA_W-1:0] regRdData_r, // Read data
  output logic regRdValid_r, // Read data valid, one cycle
  input wire logic adaptValid, // Adapted boost available
  input wire logic [7:0] adaptBoost, // Adapted stage boost fields
  input wire logic lowRateActive, // Input runs at 270 Mbps
  input wire logic inputBSelected, // Input B is the selected input
  input wire logic cdrLockRaw, // Clock recovery lock level
  input wire logic inputADetectRaw, // Input A signal detect level
  input wire logic inputBDetectRaw, // Input B signal detect level
  input wire logic eyeThresholdRaw, // Eye monitor threshold level
  output rxeq_ctrl_type ctrl_r, // Controls toward the receiver
  output logic irq_r // Masked interrupt request
);

  initial
  begin
    if (DATA_W != 8)
    begin
      $error("DATA_W must be 8");
    end
  end

  function automatic logic hit(input logic [7:0] addr, input logic [7:0] offset);
    hit = (addr == offset);
  endfunction

  function automatic logic [7:0] merge(input logic [7:0] old, input logic [7:0] data,
                                       input logic [7:0] wmask);
    merge = (old & ~wmask) | (data & wmask);
  endfunction

  logic [7:0] eqStageBoost_r;
  logic [7:0] eqStageBoost_nxt;
  logic [7:0] adaptedBoost_r;
  logic [7:0] adaptedBoost_nxt;
  logic [7:0] lowRateEqBypass_r;
  logic [7:0] lowRateEqBypass_nxt;
  logic [7:0] eqBypassPowerDown_r;
  logic [7:0] eqBypassPowerDown_nxt;
  logic [7:0] boostOverride_r;
  logic [7:0] boostOverride_nxt;
  logic [7:0] interruptMask_r;
  logic [7:0] interruptMask_nxt;
  logic [DATA_W-1:0] regRdData_nxt;
  rxeq_ctrl_type ctrl_nxt;
  logic [NUM_LEVELS-1:0] levels;
  logic [6:0] status;
  logic [7:0] statusRead;

  // Accesses reach this bank only when the host has selected channel space
  wire logic wrAccess = regWrEn & channelSpaceSelect;
  wire logic rdAccess = regRdEn & channelSpaceSelect;

  wire logic wrBoost = wrAccess & hit(regAddr, OFF_EQ_STAGE_BOOST);
  wire logic wrLowRate = wrAccess & hit(regAddr, OFF_LOW_RATE_EQ_BYPASS);
  wire logic wrBypassPd = wrAccess & hit(regAddr, OFF_EQ_BYPASS_POWER_DOWN);
  wire logic wrOverride = wrAccess & hit(regAddr, OFF_BOOST_OVERRIDE);
  wire logic wrMask = wrAccess & hit(regAddr, OFF_INTERRUPT_MASK);
  wire logic rdStatus = rdAccess & hit(regAddr, OFF_INTERRUPT_STATUS);

  wire logic overrideOn = boostOverride_r[BIT_BOOST_OVERRIDE_ENABLE];
  wire logic manualBypass = eqBypassPowerDown_r[BIT_LATE_STAGE_BYPASS];
  wire logic autoBypass = lowRateEqBypass_r[BIT_LOW_RATE_AUTO_BYPASS];
  wire logic eqOff = eqBypassPowerDown_r[BIT_SELECTED_EQUALIZER_OFF];

  // Host write wins over an adaptation result in the same cycle
  assign eqStageBoost_nxt = wrBoost ? regWrData :
                            (adaptValid & ~overrideOn) ? adaptBoost :
                            eqStageBoost_r;
  assign adaptedBoost_nxt = adaptValid ? adaptBoost : adaptedBoost_r;
  assign lowRateEqBypass_nxt = wrLowRate ?
                               merge(lowRateEqBypass_r, regWrData, WMASK_LOW_RATE_EQ_BYPASS) :
                               lowRateEqBypass_r;
  // Reserved bits 7 and 4 hold their reset ones
  assign eqBypassPowerDown_nxt = wrBypassPd ?
                                 merge(eqBypassPowerDown_r, regWrData,
                                       WMASK_EQ_BYPASS_POWER_DOWN) :
                                 eqBypassPowerDown_r;
  assign boostOverride_nxt = wrOverride ?
                             merge(boostOverride_r, regWrData, WMASK_BOOST_OVERRIDE) :
                             boostOverride_r;
  assign interruptMask_nxt = wrMask ?
                             merge(interruptMask_r, regWrData, WMASK_INTERRUPT_MASK) :
                             interruptMask_r;

  // Boost presented to the equalizer
  assign ctrl_nxt.stageBoost = overrideOn ? eqStageBoost_r : adaptedBoost_r;
  assign ctrl_nxt.eqBypass = manualBypass | (autoBypass & lowRateActive);
  assign ctrl_nxt.lateStageBypass = manualBypass;
  assign ctrl_nxt.inputAEqOn = ~eqOff & ~inputBSelected;
  assign ctrl_nxt.inputBEqOn = ~eqOff & inputBSelected;
  assign ctrl_nxt.inputADetectorOff = eqBypassPowerDown_r[BIT_INPUT_A_DETECTOR_OFF];
  assign ctrl_nxt.inputBDetectorOff = eqBypassPowerDown_r[BIT_INPUT_B_DETECTOR_OFF];

  // Top status bit shows the present detect level of the selected input
  assign statusRead = {inputBSelected ? levels[LVL_INPUT_B] : levels[LVL_INPUT_A], status};

  assign regRdData_nxt =
    !rdAccess ? 8'h00 :
    hit(regAddr, OFF_EQ_STAGE_BOOST) ? eqStageBoost_r :
    hit(regAddr, OFF_LOW_RATE_EQ_BYPASS) ? lowRateEqBypass_r :
    hit(regAddr, OFF_EQ_BYPASS_POWER_DOWN) ? eqBypassPowerDown_r :
    hit(regAddr, OFF_BOOST_OVERRIDE) ? boostOverride_r :
    hit(regAddr, OFF_DRIVEN_BOOST) ? ctrl_r.stageBoost :
    hit(regAddr, OFF_INTERRUPT_STATUS) ? statusRead :
    hit(regAddr, OFF_INTERRUPT_MASK) ? interruptMask_r :
    8'h00;

  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      eqStageBoost_r <= RST_EQ_STAGE_BOOST;
      adaptedBoost_r <= RST_EQ_STAGE_BOOST;
      lowRateEqBypass_r <= RST_LOW_RATE_EQ_BYPASS;
      eqBypassPowerDown_r <= RST_EQ_BYPASS_POWER_DOWN;
      boostOverride_r <= RST_BOOST_OVERRIDE;
      interruptMask_r <= RST_INTERRUPT_MASK;
    end
    else
    begin
      eqStageBoost_r <= eqStageBoost_nxt;
      adaptedBoost_r <= adaptedBoost_nxt;
      lowRateEqBypass_r <= lowRateEqBypass_nxt;
      eqBypassPowerDown_r <= eqBypassPowerDown_nxt;
      boostOverride_r <= boostOverride_nxt;
      interruptMask_r <= interruptMask_nxt;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      regRdData_r <= '0;
      regRdValid_r <= 1'b0;
      ctrl_r <= RST_CTRL;
    end
    else
    begin
      regRdData_r <= regRdData_nxt;
      regRdValid_r <= rdAccess;
      ctrl_r <= ctrl_nxt;
    end
  end

  rxeq_event_capture #(
    .SYNC_STAGES(SYNC_STAGES)
  ) u_events (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .rawLevels({cdrLockRaw, inputBDetectRaw, inputADetectRaw, eyeThresholdRaw}),
    .clearStatus(rdStatus),
    .irqMask(interruptMask_r),
    .levels_r(levels),
    .status_r(status),
    .irq_r(irq_r)
  );

endmodule

// *** rxeq_regs_monitor.sv ***
// Port checker for the equalizer and interrupt mask register bank
`timescale 1ns/1ps
module rxeq_regs_monitor
  import rxeq_pkg::*;
#(
  parameter int DATA_W = 8,
  parameter int SYNC_STAGES = 2
)
(
  input wire logic ref_clk, // Clock
  input wire logic rst_n, // Reset
  input wire logic channelSpaceSelect, // Select
  input wire logic [7:0] regAddr, // Address
  input wire logic [DATA_W-1:0] regWrData, // Write data
  input wire logic regWrEn, // Write strobe
  input wire logic regRdEn, // Read strobe
  input wire logic [DATA_W-1:0] regRdData_r, // Read data
  input wire logic regRdValid_r, // Read valid
  input wire logic adaptValid, // Adapted valid
  input wire logic [7:0] adaptBoost, // Adapted boost
  input wire logic lowRateActive, // Low rate
  input wire logic inputBSelected, // Input select
  input wire logic cdrLockRaw, // Lock level
  input wire logic inputADetectRaw, // Detect A
  input wire logic inputBDetectRaw, // Detect B
  input wire logic eyeThresholdRaw, // Eye level
  input wire rxeq_ctrl_type ctrl_r, // Controls
  input wire logic irq_r // Interrupt
);
  logic [7:0] cfg_r;
  logic [7:0] lowRate_r;
  logic [7:0] mask_r;
  logic ovr_r;
  wire wrHit = regWrEn && channelSpaceSelect;
  wire rdHit = regRdEn && channelSpaceSelect;
  wire [7:0] wd = regWrData[7:0];
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!rst_n);
  // Shadow copies of the writable fields, updated like the bank itself
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cfg_r <= RST_EQ_BYPASS_POWER_DOWN;
      lowRate_r <= RST_LOW_RATE_EQ_BYPASS;
      mask_r <= RST_INTERRUPT_MASK;
      ovr_r <= RST_BOOST_OVERRIDE[BIT_BOOST_OVERRIDE_ENABLE];
    end
    else if (wrHit)
    begin
      if (regAddr == OFF_EQ_BYPASS_POWER_DOWN)
        cfg_r <= (cfg_r & ~WMASK_EQ_BYPASS_POWER_DOWN) | (wd & WMASK_EQ_BYPASS_POWER_DOWN);
      if (regAddr == OFF_LOW_RATE_EQ_BYPASS)
        lowRate_r <= wd & WMASK_LOW_RATE_EQ_BYPASS;
      if (regAddr == OFF_INTERRUPT_MASK)
        mask_r <= wd & WMASK_INTERRUPT_MASK;
      if (regAddr == OFF_BOOST_OVERRIDE)
        ovr_r <= wd[BIT_BOOST_OVERRIDE_ENABLE];
    end
  end
  sequence boostWrite;
    wrHit && regAddr == OFF_EQ_STAGE_BOOST && ovr_r ##1
      ovr_r && !(wrHit && regAddr == OFF_EQ_STAGE_BOOST);
  endsequence
  sequence adaptNoOverride;
    adaptValid ##1 !ovr_r;
  endsequence
  host_boost_a: assert property (boostWrite |=> ctrl_r.stageBoost == $past(wd, 2))
    else $error("host boost not driven");
  adapt_boost_a: assert property (adaptNoOverride |=>
    ctrl_r.stageBoost == $past(adaptBoost, 2)) else $error("adapted boost not driven");
  read_answer_a: assert property (rdHit |=> regRdValid_r)
    else $error("read not answered");
  read_idle_a: assert property (!rdHit |=> !regRdValid_r && regRdData_r == '0)
    else $error("read data without accepted read");
  mask_readback_a: assert property (rdHit && regAddr == OFF_INTERRUPT_MASK |=>
    regRdData_r == $past(mask_r)) else $error("mask read mismatch");
  cfg_readback_a: assert property (rdHit && regAddr == OFF_EQ_BYPASS_POWER_DOWN |=>
    regRdData_r == $past(cfg_r)) else $error("bypass register read mismatch");
  driven_boost_a: assert property (rdHit && regAddr == OFF_DRIVEN_BOOST |=>
    regRdData_r == $past(ctrl_r.stageBoost)) else $error("driven boost read mismatch");
  eq_bypass_a: assert property (rst_n |=> ctrl_r.eqBypass ==
    $past(cfg_r[1] | (lowRate_r[0] & lowRateActive))) else $error("bypass wrong");
  late_stage_a: assert property (rst_n |=> ctrl_r.lateStageBypass == $past(cfg_r[1]))
    else $error("late stage bypass wrong");
  eq_power_a: assert property (rst_n |=>
    ctrl_r.inputAEqOn == $past(!cfg_r[3] && !inputBSelected)
    && ctrl_r.inputBEqOn == $past(!cfg_r[3] && inputBSelected)) else $error("eq power wrong");
  detector_off_a: assert property (rst_n |=> ctrl_r.inputADetectorOff == $past(cfg_r[6])
    && ctrl_r.inputBDetectorOff == $past(cfg_r[5])) else $error("detector power wrong");
  irq_quiet_a: assert property (mask_r == 8'h00 && $past(mask_r) == 8'h00 |-> !irq_r)
    else $error("interrupt with all causes masked");
endmodule

bind rxeq_regs rxeq_regs_monitor #(.DATA_W(DATA_W), .SYNC_STAGES(SYNC_STAGES))
  i_rxeq_regs_monitor (
  .ref_clk(ref_clk), .rst_n(rst_n), .channelSpaceSelect(channelSpaceSelect),
  .regAddr(regAddr), .regWrData(regWrData), .regWrEn(regWrEn), .regRdEn(regRdEn),
  .regRdData_r(regRdData_r), .regRdValid_r(regRdValid_r), .adaptValid(adaptValid),
  .adaptBoost(adaptBoost), .lowRateActive(lowRateActive), .inputBSelected(inputBSelected),
  .cdrLockRaw(cdrLockRaw), .inputADetectRaw(inputADetectRaw),
  .inputBDetectRaw(inputBDetectRaw), .eyeThresholdRaw(eyeThresholdRaw),
  .ctrl_r(ctrl_r), .irq_r(irq_r)
);

// *** rxeq_host_model.sv ***
// Host model driving the channel register strobe port
`timescale 1ns/1ps
module rxeq_host_model
(
  input wire logic ref_clk, // Clock
  input wire logic [7:0] regRdData_r, // Read data
  input wire logic regRdValid_r, // Read valid
  output logic channelSpaceSelect, // Channel space select
  output logic [7:0] regAddr, // Address
  output logic [7:0] regWrData, // Write data
  output logic regWrEn, // Write strobe
  output logic regRdEn // Read strobe
);
  initial
  begin
    channelSpaceSelect = 1'b1;
    regAddr = 8'h00;
    regWrData = 8'h00;
    regWrEn = 1'b0;
    regRdEn = 1'b0;
  end
  task automatic select(input logic s);
    @(posedge ref_clk);
    #2;
    channelSpaceSelect = s;
  endtask
  // Idle lines carry the inverse of the last value so stale data never looks live
  task automatic access(input logic wr, input logic [7:0] a, input logic [7:0] d,
                        output logic [7:0] q, output logic v);
    @(posedge ref_clk);
    #2;
    regAddr = a;
    regWrData = d;
    regWrEn = wr;
    regRdEn = !wr;
    @(posedge ref_clk);
    #2;
    // Answer stands for the cycle after the taking edge; read it clear of both edges
    q = regRdData_r;
    v = regRdValid_r;
    regWrEn = 1'b0;
    regRdEn = 1'b0;
    regAddr = ~a;
    regWrData = ~d;
    @(posedge ref_clk);
    #2;
  endtask
endmodule

// *** tb_rxeq_regs.sv ***
// Testbench of the equalizer and interrupt mask register bank
`timescale 1ns/1ps
module tb_rxeq_regs
  import rxeq_pkg::*;
;
  logic ref_clk = 1'b0;
  logic rst_n = 1'b0;
  logic adaptValid = 1'b0;
  logic [7:0] adaptBoost = 8'h00;
  logic lowRateActive = 1'b0;
  logic inputBSelected = 1'b0;
  logic [3:0] lv = 4'h0;
  wire sel;
  wire [7:0] addr;
  wire [7:0] wd;
  wire [7:0] rdData;
  wire wrEn;
  wire rdEn;
  wire rdValid;
  wire irq;
  rxeq_ctrl_type ctrl;
  logic [7:0] q;
  logic v;
  int error_cnt = 0;
  int n_compared = 0;
  // Levels {lock, B, A, eye} beside the status byte they must leave
  logic [11:0] rows [7] = '{12'h840, 12'h004, 12'h290, 12'h001, 12'h420, 12'h002, 12'h108};
  always #25 ref_clk = ~ref_clk;
  rxeq_regs i_rxeq_regs (
    .ref_clk(ref_clk), .rst_n(rst_n), .channelSpaceSelect(sel), .regAddr(addr),
    .regWrData(wd), .regWrEn(wrEn), .regRdEn(rdEn), .regRdData_r(rdData),
    .regRdValid_r(rdValid), .adaptValid(adaptValid), .adaptBoost(adaptBoost),
    .lowRateActive(lowRateActive), .inputBSelected(inputBSelected), .cdrLockRaw(lv[3]),
    .inputBDetectRaw(lv[2]), .inputADetectRaw(lv[1]), .eyeThresholdRaw(lv[0]),
    .ctrl_r(ctrl), .irq_r(irq)
  );
  rxeq_host_model i_rxeq_host_model (
    .ref_clk(ref_clk), .regRdData_r(rdData), .regRdValid_r(rdValid),
    .channelSpaceSelect(sel), .regAddr(addr), .regWrData(wd), .regWrEn(wrEn), .regRdEn(rdEn)
  );
  task automatic compare(input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    i_rxeq_host_model.access(1'b1, a, d, q, v);
  endtask
  task automatic rdChk(input logic [7:0] a, input logic [7:0] exp);
    i_rxeq_host_model.access(1'b0, a, 8'h00, q, v);
    compare({7'h00, v}, 8'h01);
    compare(q, exp);
  endtask
  task automatic settle();
    repeat (2) @(posedge ref_clk);
    #2;
  endtask
  task automatic pulseAdapt(input logic [7:0] d);
    adaptBoost = d;
    adaptValid = 1'b1;
    @(posedge ref_clk);
    #2;
    adaptValid = 1'b0;
    settle();
  endtask
  task automatic report_and_stop();
    $display("Compared %0d, mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  initial
  begin
    repeat (3000) @(posedge ref_clk);
    error_cnt++;
    report_and_stop();
  end
  initial
  begin
    repeat (8) @(posedge ref_clk);
    #2;
    rst_n = 1'b1;
    rdChk(OFF_INTERRUPT_STATUS, 8'h00);
    for (int i = 0; i < 7; i++)
    begin
      lv = rows[i][11:8];
      repeat (5) @(posedge ref_clk);
      #2;
      compare({7'h00, irq}, 8'h00);
      wr(OFF_INTERRUPT_MASK, rows[i][7:0] & 8'h7f);
      settle();
      compare({7'h00, irq}, 8'h01);
      rdChk(OFF_INTERRUPT_STATUS, rows[i][7:0]);
      compare({7'h00, irq}, 8'h00);
      wr(OFF_INTERRUPT_MASK, 8'h00);
    end
    wr(OFF_LOW_RATE_EQ_BYPASS, 8'h01);
    lowRateActive = 1'b1;
    settle();
    compare({7'h00, ctrl.eqBypass}, 8'h01);
    lowRateActive = 1'b0;
    settle();
    compare({7'h00, ctrl.eqBypass}, 8'h00);
    wr(OFF_EQ_BYPASS_POWER_DOWN, 8'h92);
    settle();
    compare({6'h00, ctrl.eqBypass, ctrl.lateStageBypass}, 8'h03);
    wr(OFF_EQ_BYPASS_POWER_DOWN, 8'hf8);
    settle();
    compare({4'h0, ctrl.inputADetectorOff, ctrl.inputBDetectorOff, ctrl.inputAEqOn,
             ctrl.inputBEqOn}, 8'h0c);
    wr(OFF_EQ_BYPASS_POWER_DOWN, 8'h90);
    inputBSelected = 1'b1;
    settle();
    compare({4'h0, ctrl.inputADetectorOff, ctrl.inputBDetectorOff, ctrl.inputAEqOn,
             ctrl.inputBEqOn}, 8'h01);
    pulseAdapt(8'h5a);
    rdChk(OFF_EQ_STAGE_BOOST, 8'h80);
    rdChk(OFF_DRIVEN_BOOST, 8'h80);
    wr(OFF_BOOST_OVERRIDE, 8'h80);
    settle();
    rdChk(OFF_DRIVEN_BOOST, 8'h5a);
    pulseAdapt(8'h1b);
    rdChk(OFF_EQ_STAGE_BOOST, 8'h1b);
    rdChk(OFF_DRIVEN_BOOST, 8'h1b);
    wr(OFF_BOOST_OVERRIDE, 8'h88);
    wr(OFF_EQ_STAGE_BOOST, 8'h3c);
    settle();
    rdChk(OFF_DRIVEN_BOOST, 8'h3c);
    i_rxeq_host_model.select(1'b0);
    wr(OFF_INTERRUPT_MASK, 8'h7f);
    i_rxeq_host_model.access(1'b0, OFF_INTERRUPT_MASK, 8'h00, q, v);
    compare({7'h00, v}, 8'h00);
    i_rxeq_host_model.select(1'b1);
    rdChk(OFF_INTERRUPT_MASK, 8'h00);
    wr(OFF_DRIVEN_BOOST, 8'h00);
    rdChk(OFF_DRIVEN_BOOST, 8'h3c);
    rst_n = 1'b0;
    repeat (8) @(posedge ref_clk);
    #2;
    rst_n = 1'b1;
    rdChk(OFF_EQ_STAGE_BOOST, 8'h80);
    rdChk(OFF_LOW_RATE_EQ_BYPASS, 8'h00);
    rdChk(OFF_EQ_BYPASS_POWER_DOWN, 8'h90);
    rdChk(OFF_BOOST_OVERRIDE, 8'h88);
    rdChk(OFF_INTERRUPT_MASK, 8'h00);
    compare(ctrl.stageBoost, 8'h80);
    report_and_stop();
  end
endmodule
